//--- ict_top.sv
// Eight-bit input capture timer with APB register access
`timescale 1ns/100ps

// Overview of operation
// - The capture interrupt fires on a rising input edge when the edge select bit is 0 and on a falling edge when it is 1.
// - With the clear field at binary 10 the counter returns to zero on each rising input edge.
// - With both clock select bits zero the counter advances once every 64 system clocks.
// - The counter is an eight-bit up-counter on the selected count clock that software cannot read or write.
// - A rising input edge copies the current counter value into the captured count register.
// - The captured count is an eight-bit read-only register and writes leave it unchanged.
// - An overflow while the input is high sets the high-level overflow flag, zero meaning none seen.
// - An overflow while the input is low sets the low-level overflow flag, zero meaning none seen.
// - The overflow interrupt request is raised only while the overflow interrupt enable bit is 1.
module ict_top
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ict_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       capture_in,
  output logic                            capture_irq,
  output logic                            overflow_irq
);

  // Register state
  logic [7:0]               mode_r;
  logic [7:0]               mode_nxt;
  logic [7:0]               captured_r;
  logic [7:0]               captured_nxt;
  logic [7:0]               counter_r;
  logic [7:0]               counter_nxt;
  logic [ict_pkg::PRE_W-1:0] pre_r;
  logic [ict_pkg::PRE_W-1:0] pre_nxt;
  logic                     cap_prev_r;
  logic                     cap_prev_nxt;
  logic                     cap_irq_r;
  logic                     cap_irq_nxt;
  logic [31:0]              rdata_r;
  logic [31:0]              rdata_nxt;

  // Decoded control and events
  logic                     hit_mode;
  logic                     hit_captured;
  logic                     setup_ph;
  logic                     wr_mode;
  logic                     rise;
  logic                     fall;
  logic                     tick;
  logic                     clear_evt;
  logic                     overflow_evt;
  logic [1:0]               clr_sel;
  logic [1:0]               cks_sel;
  logic [ict_pkg::PRE_W-1:0] pre_mask;

  assign clr_sel = {mode_r[ict_pkg::BIT_CLR_HI], mode_r[ict_pkg::BIT_CLR_LO]};
  assign cks_sel = {mode_r[ict_pkg::BIT_CKS_HI], mode_r[ict_pkg::BIT_CKS_LO]};

  // APB decode; the slave never inserts wait states
  assign hit_mode     = (paddr == ict_pkg::ADDR_MODE);
  assign hit_captured = (paddr == ict_pkg::ADDR_CAPTURED);
  assign setup_ph     = psel && !penable;
  assign wr_mode      = psel && penable && pwrite && hit_mode && pstrb[0];
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !(hit_mode || hit_captured);
  assign prdata       = rdata_r;

  // Input is taken as synchronous, so one stage is enough for edges
  assign rise = capture_in && !cap_prev_r;
  assign fall = !capture_in && cap_prev_r;

  // Prescaler: a free-running divider sampled by a mask per ratio
  always_comb
  begin
    case (cks_sel)
      ict_pkg::CKS_DIV64:
        pre_mask = ict_pkg::PRE_W'(ict_pkg::DIV_64 - 1);
      ict_pkg::CKS_DIV32:
        pre_mask = ict_pkg::PRE_W'(ict_pkg::DIV_32 - 1);
      ict_pkg::CKS_DIV16:
        pre_mask = ict_pkg::PRE_W'(ict_pkg::DIV_16 - 1);
      ict_pkg::CKS_DIV4:
        pre_mask = ict_pkg::PRE_W'(ict_pkg::DIV_4 - 1);
      default:
        pre_mask = ict_pkg::PRE_W'(ict_pkg::DIV_64 - 1);
    endcase
  end

  assign tick = ((pre_r & pre_mask) == pre_mask);

  always_comb
  begin
    pre_nxt = pre_r + ict_pkg::PRE_W'(1);
  end

  // Counter clear on the selected input edge
  always_comb
  begin
    case (clr_sel)
      ict_pkg::CLR_NONE:
        clear_evt = 1'b0;
      ict_pkg::CLR_FALLING:
        clear_evt = fall;
      ict_pkg::CLR_RISING:
        clear_evt = rise;
      ict_pkg::CLR_BOTH:
        clear_evt = rise || fall;
      default:
        clear_evt = 1'b0;
    endcase
  end

  // A clear in the same cycle as a wrap suppresses the overflow
  assign overflow_evt = tick && !clear_evt &&
                        (counter_r == ict_pkg::COUNT_MAX);

  // Counter: no bus path reaches it
  always_comb
  begin
    counter_nxt = counter_r;
    if (clear_evt)
    begin
      counter_nxt = ict_pkg::COUNTER_RESET;
    end
    else if (tick)
    begin
      counter_nxt = counter_r + 8'h01;
    end
  end

  // Captured value: only a rising edge loads it, the bus never does
  always_comb
  begin
    captured_nxt = captured_r;
    if (rise)
    begin
      captured_nxt = counter_r;
    end
  end

  // Mode register; flags clear by writing 0, a hardware set wins
  always_comb
  begin
    mode_nxt = mode_r;
    if (wr_mode)
    begin
      mode_nxt[5:0] = pwdata[5:0];
      mode_nxt[ict_pkg::BIT_OVF_HIGH] = mode_r[ict_pkg::BIT_OVF_HIGH] &&
                                        pwdata[ict_pkg::BIT_OVF_HIGH];
      mode_nxt[ict_pkg::BIT_OVF_LOW]  = mode_r[ict_pkg::BIT_OVF_LOW] &&
                                        pwdata[ict_pkg::BIT_OVF_LOW];
    end
    if (overflow_evt && capture_in)
    begin
      mode_nxt[ict_pkg::BIT_OVF_HIGH] = 1'b1;
    end
    if (overflow_evt && !capture_in)
    begin
      mode_nxt[ict_pkg::BIT_OVF_LOW] = 1'b1;
    end
  end

  // Capture interrupt pulse on the selected edge
  always_comb
  begin
    cap_prev_nxt = capture_in;
    if (mode_r[ict_pkg::BIT_IRQ_EDGE])
    begin
      cap_irq_nxt = fall;
    end
    else
    begin
      cap_irq_nxt = rise;
    end
  end

  assign overflow_irq = mode_r[ict_pkg::BIT_OVF_IE] &&
                        (mode_r[ict_pkg::BIT_OVF_HIGH] ||
                         mode_r[ict_pkg::BIT_OVF_LOW]);
  assign capture_irq  = cap_irq_r;

  // Read data is latched in the setup cycle so it comes from a flop
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (setup_ph && !pwrite)
    begin
      if (hit_mode)
      begin
        rdata_nxt = {24'h000000, mode_r};
      end
      else if (hit_captured)
      begin
        rdata_nxt = {24'h000000, captured_r};
      end
      else
      begin
        rdata_nxt = 32'h00000000;
      end
    end
  end

  // Prescaler runs free; mode writes never restart it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_r <= '0;
    end
    else
    begin
      pre_r <= pre_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      counter_r <= ict_pkg::COUNTER_RESET;
    end
    else
    begin
      counter_r <= counter_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      captured_r <= ict_pkg::CAPTURED_RESET;
    end
    else
    begin
      captured_r <= captured_nxt;
    end
  end

  // Flags and controls share one register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= ict_pkg::MODE_RESET;
    end
    else
    begin
      mode_r <= mode_nxt;
    end
  end

  // Edge history and the interrupt pulse
  // Reset low matches the idle input, so no false edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_prev_r <= 1'b0;
      cap_irq_r  <= 1'b0;
    end
    else
    begin
      cap_prev_r <= cap_prev_nxt;
      cap_irq_r  <= cap_irq_nxt;
    end
  end

  // Read data stays until the next read setup
  // Latching at setup costs a cycle of age but keeps prdata a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_r <= 32'h00000000;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

endmodule

//--- ict_pkg.sv
// Constants for the eight-bit input capture timer
package ict_pkg;

  // Register indices and their APB byte addresses (index times four)
  localparam logic [15:0] IDX_MODE     = 16'hffbc;
  localparam logic [15:0] IDX_CAPTURED = 16'hffbe;
  localparam int          ADDR_W       = 18;
  localparam logic [17:0] ADDR_MODE     = {IDX_MODE, 2'b00};
  localparam logic [17:0] ADDR_CAPTURED = {IDX_CAPTURED, 2'b00};

  // Mode register field positions
  localparam int BIT_OVF_HIGH  = 7;
  localparam int BIT_OVF_LOW   = 6;
  localparam int BIT_OVF_IE    = 5;
  localparam int BIT_IRQ_EDGE  = 4;
  localparam int BIT_CLR_HI    = 3;
  localparam int BIT_CLR_LO    = 2;
  localparam int BIT_CKS_HI    = 1;
  localparam int BIT_CKS_LO    = 0;

  // Reset values
  localparam logic [7:0] MODE_RESET     = 8'h00;
  localparam logic [7:0] CAPTURED_RESET = 8'h00;
  localparam logic [7:0] COUNTER_RESET  = 8'h00;

  // Counter clear selections
  localparam logic [1:0] CLR_NONE    = 2'h0;
  localparam logic [1:0] CLR_FALLING = 2'h1;
  localparam logic [1:0] CLR_RISING  = 2'h2;
  localparam logic [1:0] CLR_BOTH    = 2'h3;

  // Count clock selections and their divide ratios
  localparam logic [1:0] CKS_DIV64 = 2'h0;
  localparam logic [1:0] CKS_DIV32 = 2'h1;
  localparam logic [1:0] CKS_DIV16 = 2'h2;
  localparam logic [1:0] CKS_DIV4  = 2'h3;
  localparam int         DIV_64    = 64;
  localparam int         DIV_32    = 32;
  localparam int         DIV_16    = 16;
  localparam int         DIV_4     = 4;
  localparam int         PRE_W     = 6;

  localparam logic [7:0] COUNT_MAX = 8'hff;

endpackage

//--- ict_gap_placeholder_none.sv
// Intentionally empty: no further design units
`timescale 1ns/100ps

//--- ict_src.sv
// Model of the external capture signal source
`timescale 1ns/100ps
module ict_src
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic [11:0] len,
  output logic             capture_in
);
  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;
  // Level held for len cycles, so both short and long pulses are possible
  always_comb
  begin
    cnt_nxt = go ? len : cnt_r - 12'(cnt_r != '0);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end
  assign capture_in = cnt_r != '0;
endmodule

//--- ict_sva.sv
// Port checker for the input capture timer
`timescale 1ns/100ps
module ict_sva
(
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [ict_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire logic                       pslverr,
  input wire logic                       capture_in,
  input wire logic                       capture_irq,
  input wire logic                       overflow_irq
);
  logic       ie_r;
  logic       edg_r;
  logic       hv_r;
  logic       rose_r;
  logic [7:0] lv_r;
  wire acc = psel && penable;
  wire rd_cap = acc && !pwrite && paddr == ict_pkg::ADDR_CAPTURED;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mode bits are hidden, so they are shadowed from bus writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {ie_r, edg_r, hv_r, lv_r, rose_r} <= '0;
    else
    begin
      // A rise at a read's setup edge leaves older data in its access
      rose_r <= $rose(capture_in);
      if (acc && pwrite && paddr == ict_pkg::ADDR_MODE && pstrb[0])
        {ie_r, edg_r} <= pwdata[5:4];
      if ($rose(capture_in))
        hv_r <= 1'h0;
      else if (rd_cap && !rose_r)
        {hv_r, lv_r} <= {1'h1, prdata[7:0]};
    end
  end
  sequence s_rise;
    $rose(capture_in) && !edg_r;
  endsequence
  sequence s_fall;
    $fell(capture_in) && edg_r;
  endsequence
  a_irq_rise: assert property (s_rise |=> capture_irq)
    else $error("no irq after rise");
  a_irq_fall: assert property (s_fall |=> capture_irq)
    else $error("no irq after fall");
  a_irq_cause: assert property (capture_irq |->
    $past(capture_in) != $past(capture_in, 2) &&
    $past(capture_in) != $past(edg_r))
    else $error("irq without selected edge");
  a_irq_single: assert property (capture_irq |=> !capture_irq)
    else $error("irq longer than a cycle");
  a_ovf_gate: assert property (!ie_r |-> !overflow_irq)
    else $error("overflow irq while disabled");
  a_read_upper: assert property (acc && !pwrite |-> !(|prdata[31:8]))
    else $error("read upper bits set");
  a_cap_hold: assert property (rd_cap && hv_r |-> prdata[7:0] == lv_r)
    else $error("captured count changed");
  a_unmapped_err: assert property (acc && paddr != ict_pkg::ADDR_MODE &&
    paddr != ict_pkg::ADDR_CAPTURED |-> pslverr)
    else $error("no error on unmapped access");
endmodule
bind ict_top ict_sva ict_sva_i (.*);

//--- ict_top_tb.sv
// Self-checking testbench of the input capture timer
`timescale 1ns/100ps
module ict_top_tb;
  logic        pclk = '0;
  logic        presetn = '0;
  logic        psel = '0;
  logic        penable = '0;
  logic        pwrite = '0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        capture_in;
  logic        capture_irq;
  logic        overflow_irq;
  logic        go = '0;
  logic [11:0] len = '0;
  logic [31:0] exp_q[$];
  int          n_fail = 0;
  int          checks = 0;
  int          n_irq = 0;
  int          cyc = 0;
  int          k;
  int          dv;
  ict_top ict_top_i (.*);
  ict_src ict_src_i (.*);
  always #4 pclk = ~pclk;
  task automatic conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [17:0] a, input int d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'h1, w, a, d, 4'hf};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    {psel, penable} <= 2'h0;
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'h0, a, 0);
  endtask
  // Rises land on one phase of 64, so tick count between them is exact
  task automatic pulse(input int n, input int periods);
    repeat (periods)
    begin
      @(posedge pclk);
      while (cyc % 64 != 32) @(posedge pclk);
    end
    @(posedge pclk);
    {go, len} <= {1'h1, 12'(n)};
    @(posedge pclk);
    go <= 1'h0;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (capture_irq === 1'h1) n_irq++;
    if (psel && penable && pready && !pwrite)
      check("prdata", prdata, exp_q.pop_front());
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    k = $urandom(32'h46015086);
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    rd(ict_pkg::ADDR_MODE, 32'h0);
    rd(ict_pkg::ADDR_CAPTURED, 32'h0);
    apb(1'h1, ict_pkg::ADDR_CAPTURED, $urandom);
    rd(ict_pkg::ADDR_CAPTURED, 32'h0);
    rd(18'h0, 32'h0);
    apb(1'h1, ict_pkg::ADDR_MODE, 32'h08);
    pulse(3, 1);
    repeat (2)
    begin
      k = $urandom_range(4, 1);
      pulse(3, k);
      rd(ict_pkg::ADDR_CAPTURED, k);
    end
    check("irq", n_irq, 3);
    repeat (100) @(posedge pclk);
    rd(ict_pkg::ADDR_CAPTURED, k);
    apb(1'h1, ict_pkg::ADDR_MODE, 32'h10);
    pulse(5, 0);
    check("irq", n_irq, 3);
    repeat (10) @(posedge pclk);
    check("irq", n_irq, 4);
    // Both-edge clear at /32, then falling-edge clear at /16
    for (int m = 0; m < 2; m++)
    begin
      apb(1'h1, ict_pkg::ADDR_MODE, m ? 32'h06 : 32'h0d);
      pulse(3, 1);
      k = $urandom_range(4, 1);
      pulse(3, k);
      dv = m ? ict_pkg::DIV_16 : ict_pkg::DIV_32;
      rd(ict_pkg::ADDR_CAPTURED, k * ict_pkg::DIV_64 / dv);
    end
    apb(1'h1, ict_pkg::ADDR_MODE, 32'h23);
    repeat (1100) @(posedge pclk);
    rd(ict_pkg::ADDR_MODE, 32'h63);
    check("ovf", overflow_irq, 1);
    pulse(1100, 0);
    apb(1'h1, ict_pkg::ADDR_MODE, 32'h03);
    repeat (1050) @(posedge pclk);
    rd(ict_pkg::ADDR_MODE, 32'h83);
    check("ovf", overflow_irq, 0);
    conclude();
  end
endmodule
